// ---- rtl/lfe_pkg.sv ----
// constants, register map and state type of the led output and fault controller
package lfe_pkg;
   localparam int NCH = 24;
   // register byte offsets
   localparam logic [11:0] OFF_MODE = 12'h000;
   localparam logic [11:0] OFF_GDUTY = 12'h004;
   localparam logic [11:0] OFF_GFREQ = 12'h008;
   localparam logic [11:0] OFF_DELAY = 12'h00C;
   localparam logic [11:0] OFF_DRV_LO = 12'h010;
   localparam logic [11:0] OFF_DRV_HI = 12'h014;
   localparam logic [11:0] OFF_FLT_LO = 12'h018;
   localparam logic [11:0] OFF_FLT_HI = 12'h01C;
   localparam logic [11:0] OFF_PWM0 = 12'h040;
   localparam logic [11:0] OFF_PWM_END = 12'h0A0;
   // mode_ctrl_two bit positions
   localparam int MODE_THERMAL = 7;
   localparam int MODE_ERROR = 6;
   localparam int MODE_BLINK = 5;
   localparam int MODE_CLEAR_FAULT_BIT = 4;
   localparam int MODE_AUTOOFF_DIS = 3;
   // channel_fault_code values
   localparam logic [1:0] FLT_NONE = 2'h0;
   localparam logic [1:0] FLT_SHORT = 2'h1;
   localparam logic [1:0] FLT_OPEN = 2'h2;
   // drive_state_field values
   localparam logic [1:0] DRV_OFF = 2'h0;
   localparam logic [1:0] DRV_ON = 2'h1;
   localparam logic [1:0] DRV_PWM = 2'h2;
   localparam logic [1:0] DRV_GRP = 2'h3;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // timing
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned PWM_STEPS = 256;
   localparam int unsigned PWM_HZ = 31_250;
   localparam int unsigned DIM_HZ = 122;
   localparam int unsigned BLINK_HZ = 15;
   localparam int unsigned PWM_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS);
   localparam logic [4:0] PWM_LAST = 5'(PWM_DIV - 1);
   localparam int unsigned DIM_DIV = CLK_HZ / (DIM_HZ * PWM_STEPS);
   localparam int unsigned BLINK_DIV = CLK_HZ / (BLINK_HZ * PWM_STEPS);
   localparam real READY_MS = 1.5;
   localparam int unsigned READY_CYC = int'(READY_MS * 1.0e-3 * CLK_HZ);

   typedef struct packed {
      logic [NCH-1:0] opn_s1;
      logic [NCH-1:0] opn_s2;
      logic [NCH-1:0] sht_s1;
      logic [NCH-1:0] sht_s2;
      logic ot_s1;
      logic ot_s2;
      logic [4:0] pwm_pre;
      logic [7:0] pwm_cnt;
      logic [16:0] grp_pre;
      logic [7:0] blink_per;
      logic [7:0] grp_cnt;
      logic [15:0] dly_cnt;
      logic blink_sel;
      logic autooff_dis;
      logic [7:0] grp_duty;
      logic [7:0] grp_freq;
      logic [3:0] dly_step;
      logic [2*NCH-1:0] drive;
      logic [NCH-1:0][7:0] duty;
      logic [2*NCH-1:0] fault;
      logic [NCH-1:0] led_drive;
      logic [NCH-1:0] led_oe;
      logic [31:0] prdata;
      logic pslverr;
   } lfe_state_s;
endpackage

// ---- rtl/lfe_ctrl.sv ----
// led output control, group dimming/blinking and fault status with apb registers
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module lfe_ctrl
#(
   parameter int unsigned DIM_DIV = lfe_pkg::DIM_DIV,
   parameter int unsigned BLINK_DIV = lfe_pkg::BLINK_DIV
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic oe_n,
   input wire logic ot_ind,
   input wire logic [lfe_pkg::NCH-1:0] open_cmp,
   input wire logic [lfe_pkg::NCH-1:0] short_cmp,
   output logic [lfe_pkg::NCH-1:0] led_drive,
   output logic [lfe_pkg::NCH-1:0] led_oe
);
   import lfe_pkg::*;

   lfe_state_s s;
   lfe_state_s next_s;
   logic [NCH-1:0] ch_on;
   logic [NCH-1:0] ch_dly_ok;
   logic [NCH-1:0] ch_dne;
   logic [2*NCH-1:0] det;
   logic grp_hi;
   logic frozen;
   logic clr_req;
   logic wr_acc;
   logic rd_setup;
   logic [16:0] grp_lim;
   logic [5:0] pwm_idx;
   logic pwm_hit;

   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign pwm_idx = 6'(paddr[7:2] - 6'h10);
   assign pwm_hit = (paddr >= OFF_PWM0) && (paddr < OFF_PWM_END);
   assign clr_req = wr_acc && (paddr == OFF_MODE) && pwdata[MODE_CLEAR_FAULT_BIT];
   assign frozen = !s.autooff_dis && (|s.fault);
   assign grp_hi = s.grp_cnt < s.grp_duty;
   assign grp_lim = s.blink_sel ? 17'(BLINK_DIV - 1) : 17'(DIM_DIV - 1);

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_ch
         logic [1:0] st;
         logic pwm_hi;
         logic on_now;
         assign st = s.drive[2*gi +: 2];
         assign pwm_hi = s.pwm_cnt < s.duty[gi];
         assign ch_on[gi] = (st == DRV_ON) || ((st == DRV_PWM) && pwm_hi)
                            || ((st == DRV_GRP) && pwm_hi && grp_hi);
         assign ch_dly_ok[gi] = s.dly_cnt >= 16'(gi * s.dly_step);
         assign on_now = s.led_drive[gi] && s.led_oe[gi];
         assign det[2*gi +: 2] = !on_now ? FLT_NONE :
                                 s.sht_s2[gi] ? FLT_SHORT :
                                 s.opn_s2[gi] ? FLT_OPEN : FLT_NONE;
         assign ch_dne[gi] = &s.fault[2*gi +: 2];
      end
   endgenerate

   always_comb
   begin
      next_s = s;
      next_s.opn_s1 = open_cmp;
      next_s.opn_s2 = s.opn_s1;
      next_s.sht_s1 = short_cmp;
      next_s.sht_s2 = s.sht_s1;
      next_s.ot_s1 = ot_ind;
      next_s.ot_s2 = s.ot_s1;
      if (s.pwm_pre >= PWM_LAST)
      begin
         next_s.pwm_pre = 5'h00;
         next_s.pwm_cnt = s.pwm_cnt + 8'h01;
      end
      else
      begin
         next_s.pwm_pre = s.pwm_pre + 5'h01;
      end
      // group timebase, blink stretched by period register
      if (s.grp_pre >= grp_lim)
      begin
         next_s.grp_pre = 17'h00000;
         if (!s.blink_sel || (s.blink_per >= s.grp_freq))
         begin
            next_s.blink_per = 8'h00;
            next_s.grp_cnt = s.grp_cnt + 8'h01;
         end
         else
         begin
            next_s.blink_per = s.blink_per + 8'h01;
         end
      end
      else
      begin
         next_s.grp_pre = s.grp_pre + 17'h00001;
      end
      if (oe_n)
      begin
         next_s.dly_cnt = 16'h0000;
      end
      else if (s.dly_cnt != 16'hFFFF)
      begin
         next_s.dly_cnt = s.dly_cnt + 16'h0001;
      end
      // thermal gate, state kept for restore
      next_s.led_drive = ch_on & ~{NCH{s.ot_s2}};
      // outputs float while enable is high
      next_s.led_oe = ch_dly_ok & ~{NCH{oe_n}};
      // hold codes while frozen, new detections win over clear
      if (!frozen || clr_req)
      begin
         next_s.fault = det;
      end
      // register writes
      if (wr_acc)
      begin
         if (paddr == OFF_MODE)
         begin
            next_s.blink_sel = pwdata[MODE_BLINK];
            next_s.autooff_dis = pwdata[MODE_AUTOOFF_DIS];
         end
         if (paddr == OFF_GDUTY)
         begin
            next_s.grp_duty = pwdata[7:0];
         end
         if (paddr == OFF_GFREQ)
         begin
            next_s.grp_freq = pwdata[7:0];
         end
         if (paddr == OFF_DELAY)
         begin
            next_s.dly_step = pwdata[3:0];
         end
         if (paddr == OFF_DRV_LO)
         begin
            next_s.drive[31:0] = pwdata;
         end
         if (paddr == OFF_DRV_HI)
         begin
            next_s.drive[2*NCH-1:32] = pwdata[2*NCH-33:0];
         end
         if (pwm_hit)
         begin
            next_s.duty[pwm_idx[4:0]] = pwdata[7:0];
         end
      end
      // read data and error prepared in setup phase
      if (rd_setup)
      begin
         next_s.pslverr = 1'b0;
         next_s.prdata = RST_ZERO;
         unique case (1'b1)
            paddr == OFF_MODE:
            begin
               next_s.prdata[MODE_THERMAL] = s.ot_s2;
               next_s.prdata[MODE_ERROR] = |s.fault;
               next_s.prdata[MODE_BLINK] = s.blink_sel;
               next_s.prdata[MODE_AUTOOFF_DIS] = s.autooff_dis;
            end
            paddr == OFF_GDUTY: next_s.prdata[7:0] = s.grp_duty;
            paddr == OFF_GFREQ: next_s.prdata[7:0] = s.grp_freq;
            paddr == OFF_DELAY: next_s.prdata[3:0] = s.dly_step;
            paddr == OFF_DRV_LO: next_s.prdata = s.drive[31:0];
            paddr == OFF_DRV_HI: next_s.prdata[2*NCH-33:0] = s.drive[2*NCH-1:32];
            paddr == OFF_FLT_LO: next_s.prdata = s.fault[31:0];
            paddr == OFF_FLT_HI: next_s.prdata[2*NCH-33:0] = s.fault[2*NCH-1:32];
            pwm_hit: next_s.prdata[7:0] = s.duty[pwm_idx[4:0]];
            default: next_s.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // zero-wait slave, ready tied high at all times, also during reset
   assign pready = 1'b1;
   assign prdata = s.prdata;
   assign pslverr = s.pslverr && psel && penable;
   assign led_drive = s.led_drive;
   assign led_oe = s.led_oe;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_OPEN_CODE: assert property (
      s.led_drive[0] && s.led_oe[0] && !s.sht_s2[0] && s.opn_s2[0] && !frozen
      |=> s.fault[1:0] == FLT_OPEN)
      else $error("open fault not recorded");
   AST_OFF_ZERO: assert property (
      !(s.led_drive[3] && s.led_oe[3]) && !frozen |=> s.fault[7:6] == FLT_NONE)
      else $error("off channel shows a fault");
   AST_SHORT_CODE: assert property (
      s.led_drive[5] && s.led_oe[5] && s.sht_s2[5] && !frozen
      |=> s.fault[11:10] == FLT_SHORT)
      else $error("short fault not recorded");
   AST_NO_SHORT: assert property (
      !s.sht_s2[2] && !frozen |=> !s.fault[4])
      else $error("short reported without cause");
   AST_NO_DNE: assert property (
      ch_dne == '0)
      else $error("illegal fault code 11");
   AST_OT_OFF: assert property (
      ot_ind ##1 ot_ind ##1 ot_ind |=> led_drive == '0)
      else $error("outputs active in over-temperature");
   AST_OT_FLAG: assert property (
      ot_ind ##1 ot_ind |=> s.ot_s2)
      else $error("thermal flag not set");
   AST_OT_CLEAR: assert property (
      !ot_ind ##1 !ot_ind |=> !s.ot_s2)
      else $error("thermal flag not cleared");
   AST_DELAY_CH0: assert property (
      !oe_n ##1 !oe_n |=> led_oe[0])
      else $error("channel 0 not enabled");
   AST_HIZ: assert property (
      oe_n |=> led_oe == '0)
      else $error("output driven while enable high");
   AST_PWM_STEP: assert property (
      s.pwm_pre == PWM_LAST |=> s.pwm_cnt == $past(s.pwm_cnt) + 8'h01)
      else $error("pwm step missed");
   AST_HOLD: assert property (
      frozen && !clr_req |=> $stable(s.fault))
      else $error("frozen fault codes changed");
   AST_SUMMARY: assert property (
      rd_setup && paddr == OFF_MODE |=> prdata[MODE_ERROR] == $past(|s.fault))
      else $error("summary error bit wrong");

   COV_SHORT: cover property (s.fault[1:0] == FLT_SHORT);
   COV_OPEN: cover property (s.fault[1:0] == FLT_OPEN);
   COV_THERMAL: cover property (s.ot_s2 ##1 !s.ot_s2);
   COV_CLEAR: cover property (frozen ##1 clr_req);
endmodule

// ---- test/lfe_led_model.sv ----
// led string and die temperature model feeding the fault comparators
`timescale 1ns/1ps
module lfe_led_model
(
   input wire logic [lfe_pkg::NCH-1:0] led_drive,
   input wire logic [lfe_pkg::NCH-1:0] led_oe,
   input wire logic [lfe_pkg::NCH-1:0] inj_open,
   input wire logic [lfe_pkg::NCH-1:0] inj_short,
   input wire logic inj_hot,
   output logic [lfe_pkg::NCH-1:0] open_cmp,
   output logic [lfe_pkg::NCH-1:0] short_cmp,
   output logic ot_ind
);
   import lfe_pkg::*;
   // no sink current when off, so the low-current comparator trips too
   assign open_cmp = inj_open | ~(led_drive & led_oe);
   assign short_cmp = inj_short;
   assign ot_ind = inj_hot;
endmodule

// ---- test/lfe_ctrl_tb.sv ----
// self-checking bench for the led output and fault controller
`timescale 1ns/1ps
module lfe_ctrl_tb;
   import lfe_pkg::*;
   localparam int SETTLE = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oe_n, ot_ind, inj_hot, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [NCH-1:0] open_cmp, short_cmp, led_drive, led_oe, inj_open, inj_short;
   int error_cnt = 0;
   int samples_checked = 0;
   int hi;

   lfe_ctrl #(.DIM_DIV(4), .BLINK_DIV(8)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .oe_n(oe_n), .ot_ind(ot_ind),
      .open_cmp(open_cmp), .short_cmp(short_cmp), .led_drive(led_drive), .led_oe(led_oe));

   lfe_led_model i_led (.led_drive(led_drive), .led_oe(led_oe), .inj_open(inj_open),
      .inj_short(inj_short), .inj_hot(inj_hot), .open_cmp(open_cmp),
      .short_cmp(short_cmp), .ot_ind(ot_ind));

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, idle cycle first
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, exp);
   endtask

   task automatic settle;
      repeat (SETTLE) @(posedge pclk);
   endtask

   // high cycles of one channel over a window
   task automatic count_hi(input int ch, input int cyc);
      hi = 0;
      repeat (cyc)
      begin
         @(posedge pclk);
         hi += int'(led_drive[ch]);
      end
   endtask

   initial
   begin
      #100_000;
      error_cnt++;
      print_verdict;
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      oe_n = 1'b0;
      inj_hot = 1'b0;
      inj_open = '0;
      inj_short = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(pready), 32'h0000_0001);
      for (int i = 0; i < 8; i++)
         rd(12'(4 * i), RST_ZERO);
      rd(OFF_PWM0, RST_ZERO);
      apb(1'b0, OFF_PWM_END, 32'h0000_0000);
      chk({rdat[30:0], err}, 32'h0000_0001);
      wr(OFF_MODE, 32'h0000_0028);
      rd(OFF_MODE, 32'h0000_0028);
      // clear bit reads back zero
      wr(OFF_MODE, 32'h0000_0018);
      rd(OFF_MODE, 32'h0000_0008);
      wr(OFF_PWM0 + 12'h010, 32'h0000_0150);
      rd(OFF_PWM0 + 12'h010, 32'h0000_0050);
      wr(OFF_DRV_LO, 32'h0000_0005);
      settle;
      chk(32'({led_drive[1:0], led_oe[1:0]}), 32'h0000_000F);
      inj_short <= 24'h00_0005;
      inj_open <= 24'h00_0002;
      settle;
      rd(OFF_FLT_LO, 32'h0000_0009);
      rd(OFF_MODE, 32'h0000_0048);
      inj_short <= '0;
      inj_open <= '0;
      settle;
      rd(OFF_FLT_LO, RST_ZERO);
      // frozen codes with auto switch-off
      wr(OFF_MODE, 32'h0000_0000);
      inj_short <= 24'h00_0001;
      settle;
      inj_short <= '0;
      settle;
      rd(OFF_FLT_LO, 32'h0000_0001);
      wr(OFF_DRV_LO, 32'h0000_0000);
      rd(OFF_FLT_LO, 32'h0000_0001);
      wr(OFF_MODE, 32'h0000_0010);
      rd(OFF_FLT_LO, RST_ZERO);
      wr(OFF_DRV_LO, 32'h0000_0005);
      wr(OFF_MODE, 32'h0000_0008);
      inj_hot <= 1'b1;
      settle;
      rd(OFF_MODE, 32'h0000_0088);
      chk(32'({led_drive[1:0], led_oe[1:0]}), 32'h0000_0003);
      inj_hot <= 1'b0;
      settle;
      rd(OFF_MODE, 32'h0000_0008);
      chk(32'(led_drive[1:0]), 32'h0000_0003);
      wr(OFF_DELAY, 32'h0000_0002);
      wr(OFF_DRV_LO, 32'h0000_0055);
      oe_n <= 1'b1;
      settle;
      chk(32'(led_oe), 32'h0000_0000);
      oe_n <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'(led_oe[3:0]), 32'h0000_0001);
      settle;
      chk(32'(led_oe[3:0]), 32'h0000_000F);
      // channel 4 on its own pwm, count one full period
      wr(OFF_DRV_LO, 32'h0000_0200);
      settle;
      hi = 0;
      repeat (PWM_DIV * PWM_STEPS)
      begin
         @(posedge pclk);
         hi += int'(led_drive[4]);
      end
      chk(32'(hi), 32'(32'h0000_0050 * PWM_DIV));
      // channel 5 on pwm and group signal, individual duty 0xFF (high 255 of 256 steps)
      wr(OFF_PWM0 + 12'h014, 32'h0000_00FF);
      wr(OFF_GDUTY, 32'h0000_0000);
      wr(OFF_MODE, 32'h0000_0008);
      wr(OFF_DRV_LO, 32'h0000_0C00);
      settle;
      count_hi(5, 1024);
      chk(32'(hi), 32'h0000_0000);
      wr(OFF_GDUTY, 32'h0000_0080);
      settle;
      count_hi(5, 1024);
      chk(32'(hi >= 481 && hi <= 512), 32'h0000_0001);
      // blink with period register 1, step of two prescaler spans
      wr(OFF_GFREQ, 32'h0000_0001);
      wr(OFF_MODE, 32'h0000_0028);
      settle;
      count_hi(5, 4096);
      chk(32'(hi >= 2017 && hi <= 2048), 32'h0000_0001);
      print_verdict;
   end
endmodule
